// ==== fisc_pkg.sv ====
package fisc_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int NS_PER_US     = 1000;

  // Opcodes handled here
  localparam logic [7:0] OP_READ_ID_A      = 8'h9F;
  localparam logic [7:0] OP_READ_ID_B      = 8'h9E;
  localparam logic [7:0] OP_SUSPEND        = 8'h75;
  localparam logic [7:0] OP_RESUME         = 8'h7A;
  localparam logic [7:0] OP_SEC_ERASE      = 8'h44;
  localparam logic [7:0] OP_SEC_PROG       = 8'h42;
  localparam logic [7:0] OP_SEC_READ       = 8'h48;
  localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;

  // Opcodes refused while suspended (programs only in program suspend)
  localparam logic [7:0] OP_WRITE_REG_A    = 8'h01;
  localparam logic [7:0] OP_WRITE_REG_B    = 8'hB1;
  localparam logic [7:0] OP_ERASE_4K_A     = 8'h20;
  localparam logic [7:0] OP_ERASE_4K_B     = 8'h21;
  localparam logic [7:0] OP_ERASE_32K_A    = 8'h52;
  localparam logic [7:0] OP_ERASE_32K_B    = 8'h5C;
  localparam logic [7:0] OP_ERASE_64K_A    = 8'hD8;
  localparam logic [7:0] OP_ERASE_64K_B    = 8'hDC;
  localparam logic [7:0] OP_ERASE_CHIP_A   = 8'hC7;
  localparam logic [7:0] OP_ERASE_CHIP_B   = 8'h60;
  localparam logic [7:0] OP_PROG_A         = 8'h02;
  localparam logic [7:0] OP_PROG_B         = 8'h12;
  localparam logic [7:0] OP_PROG_QUAD_A    = 8'h32;
  localparam logic [7:0] OP_PROG_QUAD_B    = 8'h34;
  localparam logic [7:0] OP_PROG_EXT_A     = 8'hC2;
  localparam logic [7:0] OP_PROG_EXT_B     = 8'h3E;

  // Identification bytes, values arbitrary
  localparam logic [7:0] ID_MANUFACTURER   = 8'hA5;
  localparam logic [7:0] ID_MEMORY_TYPE    = 8'h5A;
  localparam logic [7:0] ID_CAPACITY       = 8'h3C;
  localparam logic [7:0] ID_DEVICE_LOW     = 8'hC3;
  localparam logic [1:0] ID_LAST_INDEX     = 2'h3;

  // Serial framing
  localparam logic [3:0] BYTE_BITS         = 4'h8;
  localparam logic [3:0] STEP_SPI          = 4'h1;
  localparam logic [3:0] STEP_QUAD         = 4'h4;
  localparam logic [5:0] SEC_READ_DUMMY    = 6'h08;
  localparam logic [5:0] FAST_ID_DUMMY     = 6'h20;
  localparam logic [2:0] ADDR_BYTES_SHORT  = 3'h3;
  localparam logic [2:0] ADDR_BYTES_LONG   = 3'h4;
  localparam int         SI_LANE           = 0;
  localparam int         SO_LANE           = 1;
  localparam logic [3:0] OE_N_IDLE         = 4'hF;
  localparam logic [3:0] OE_N_QUAD         = 4'h0;
  localparam logic [3:0] OE_N_SPI          = 4'hD;

  // Security region
  localparam int          SEC_BYTES        = 4096;
  localparam int          PAGE_BYTES       = 256;
  localparam logic [11:0] SEC_LAST_ADDR    = 12'hFFF;
  localparam logic [7:0]  PAGE_LAST        = 8'hFF;
  localparam logic [7:0]  ERASED_BYTE      = 8'hFF;
  localparam int          FIFO_DEPTH       = 8;

  // Suspend latency
  localparam int SUSPEND_LATENCY_NS = 1000;
  localparam int SUSPEND_CYCLES     = SUSPEND_LATENCY_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_DIN, PH_DOUT, PH_END, PH_SKIP}
    fisc_phase_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_ID, SRC_MEM} fisc_src_t;
  typedef enum logic [1:0] {SEC_IDLE, SEC_ERASE, SEC_PROG, SEC_WAIT} fisc_sec_t;

endpackage

// ==== fisc_core.sv ====
// Summary of operation
// - Identification returns manufacturer byte then three device bytes, 32 bits, MSB first.
// - First device byte is memory type, second is memory capacity.
// - Identification is not decoded while a program or erase runs.
// - Bits leave on falling clock; chip select high ends transfer anytime.
// - Four-line mode above 104MHz inserts eight dummy clocks before identification data.
// - Suspend pauses a running page program or sector/block erase only.
// - Program suspend refuses register write, security erase/program, erases, page programs.
// - Erase suspend refuses register write, security erase and erases; programs allowed.
// - Suspend accepted only with no suspend flag set and busy flag set.
// - Suspend flag sets at once; busy flag clears within the suspend latency.
// - Power loss while suspended resets the device and drops suspend state.
// - Resume accepted only when a suspend flag is set and busy is clear.
// - Resume clears suspend at once, raises busy within 200ns, finishes operation.
// - Security region is 4KB, 16 pages; upper address bits must be zero.
// - Security erase and program need the write-enable latch set first.
// - Security erase runs only if chip select rises right after last address bit.
// - Busy is set during security cycles; latch clears before the cycle ends.
// - Lock bit set makes security erase and program ignored.
// - Security program is opcode, three address bytes (four with addr4Byte), data; starts on select rise.
// - Security read takes address and dummy byte, then streams incrementing bytes.
// - Security read wraps address bits 11-0 from FFFH to 000H.
module fisc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;

  assign inReady  = (wrPtr_q - rdPtr_q) != (AW+1)'(DEPTH);
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData  = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (inValid && inReady) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (inValid && inReady) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (outValid && outReady) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end
endmodule

module fisc_core
  import fisc_pkg::*;
#(
  parameter int SEC_ERASE_TIME_US = 300,
  parameter int PROG_TIME_US      = 200
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Serial link pins
  input  wire logic       csN,
  input  wire logic       sclk,
  input  wire logic [3:0] ioIn,
  output logic      [3:0] ioOut,
  output logic      [3:0] ioOeN,
  // Mode and configuration
  input  wire logic       quadCmdMode,
  input  wire logic       highSpeedClk,
  input  wire logic       addr4Byte,
  input  wire logic       secLockBit,
  // Main array engine
  input  wire logic       mainOpActive,
  input  wire logic       mainOpErase,
  input  wire logic       mainWelClear,
  output logic            mainPause,
  // Command hand-off
  output logic      [7:0] cmdCode,
  output logic            cmdStrobe,
  output logic            cmdRefused,
  // Status flags
  output logic            writeInProgress,
  output logic            writeEnableLatch,
  output logic            suspendProgram,
  output logic            suspendErase
);
  localparam int ERASE_CYCLES =
    (SEC_ERASE_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES  =
    (PROG_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  logic [2:0]  csnSync_q, sclkSync_q;
  logic [3:0]  ioMeta_q, ioSync_q, ioOut_q, ioOeN_q;
  fisc_phase_t phase_q, cmdPhase;
  fisc_src_t   src_q;
  fisc_sec_t   sec_q;
  logic [7:0]  shift_q, opcode_q, inByte, outSr_q, outByte, cmdCode_q, pushData;
  logic [3:0]  bitCnt_q, step, bitsNext, outLeft_q, pageSel_q;
  logic [5:0]  dummy_q;
  logic [2:0]  addrCnt_q, addrBytes;
  logic [23:0] addr_q, secCnt_q;
  logic [11:0] rdAddr_q, walk_q;
  logic [7:0]  pageIdx_q;
  logic [1:0]  idIdx_q;
  logic [4:0]  latCnt_q;
  logic        selected, sclkRise, sclkFall, csRise, byteDone, cmdDone, addrDone;
  logic        gotData_q, addrOk_q, wip_q, wel_q, suspP_q, suspE_q, pause_q;
  logic        cmdStrobe_q, cmdRefused_q, execOk, eraseGo, progGo, walkLast;
  logic        push, fifoInReady, fifoOutValid, load, pop, handled, refused;
  logic [7:0]  fifoData;
  logic [7:0]  secMem [SEC_BYTES];
  logic [7:0]  pageBuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pageMask_q;

  function automatic logic isErase(input logic [7:0] op);
    return op inside {OP_ERASE_4K_A, OP_ERASE_4K_B, OP_ERASE_32K_A, OP_ERASE_32K_B,
                      OP_ERASE_64K_A, OP_ERASE_64K_B, OP_ERASE_CHIP_A, OP_ERASE_CHIP_B};
  endfunction

  function automatic logic isProgram(input logic [7:0] op);
    return op inside {OP_PROG_A, OP_PROG_B, OP_PROG_QUAD_A, OP_PROG_QUAD_B,
                      OP_PROG_EXT_A, OP_PROG_EXT_B};
  endfunction

  // Pin synchronisers and edge detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      csnSync_q  <= '1;
      sclkSync_q <= '0;
      ioMeta_q   <= '0;
      ioSync_q   <= '0;
    end else begin
      csnSync_q  <= {csnSync_q[1:0], csN};
      sclkSync_q <= {sclkSync_q[1:0], sclk};
      ioMeta_q   <= ioIn;
      ioSync_q   <= ioMeta_q;
    end
  end

  always_comb begin
    selected  = !csnSync_q[1];
    csRise    = csnSync_q[1] && !csnSync_q[2];
    sclkRise  = selected && sclkSync_q[1] && !sclkSync_q[2];
    sclkFall  = selected && !sclkSync_q[1] && sclkSync_q[2];
    step      = quadCmdMode ? STEP_QUAD : STEP_SPI;
    inByte    = quadCmdMode ? {shift_q[3:0], ioSync_q} : {shift_q[6:0], ioSync_q[SI_LANE]};
    bitsNext  = bitCnt_q + step;
    byteDone  = sclkRise && (bitsNext == BYTE_BITS);
    cmdDone   = byteDone && (phase_q == PH_CMD);
    addrBytes = addr4Byte ? ADDR_BYTES_LONG : ADDR_BYTES_SHORT;
    addrDone  = byteDone && (phase_q == PH_ADDR) && (addrCnt_q == addrBytes - 3'h1);
    case (inByte)
      OP_READ_ID_A, OP_READ_ID_B: begin
        if (wip_q) begin
          cmdPhase = PH_SKIP;
        end else begin
          cmdPhase = (quadCmdMode && highSpeedClk) ? PH_DUMMY : PH_DOUT;
        end
      end
      OP_SEC_READ, OP_SEC_ERASE, OP_SEC_PROG: begin
        cmdPhase = (sec_q != SEC_IDLE) ? PH_SKIP : PH_ADDR;
      end
      default:                   cmdPhase = PH_SKIP;
    endcase
  end

  // Command frame sequencing
  always_ff @(posedge sys_clk) begin
    if (rst || !selected) begin
      phase_q   <= PH_CMD;
      bitCnt_q  <= '0;
      shift_q   <= '0;
      opcode_q  <= '0;
      addrCnt_q <= '0;
      addr_q    <= '0;
      dummy_q   <= '0;
      gotData_q <= 1'b0;
      addrOk_q  <= 1'b0;
    end else if (sclkRise) begin
      shift_q  <= inByte;
      bitCnt_q <= byteDone ? '0 : bitsNext;
      case (phase_q)
        PH_CMD: begin
          if (byteDone) begin
            opcode_q <= inByte;
            phase_q  <= cmdPhase;
            dummy_q  <= FAST_ID_DUMMY;
          end
        end
        PH_ADDR: begin
          if (byteDone) begin
            addr_q    <= {addr_q[15:0], inByte};
            addrCnt_q <= addrCnt_q + 3'h1;
            if (addrDone) begin
              addrOk_q <= addr4Byte ? (addr_q[23:4] == '0) : (addr_q[15:4] == '0);
              dummy_q  <= SEC_READ_DUMMY;
              case (opcode_q)
                OP_SEC_READ:  phase_q <= PH_DUMMY;
                OP_SEC_ERASE: phase_q <= PH_END;
                default:      phase_q <= PH_DIN;
              endcase
            end
          end
        end
        PH_DUMMY: begin
          dummy_q <= dummy_q - 6'(step);
          if (dummy_q == 6'(step)) begin
            phase_q <= PH_DOUT;
          end
        end
        PH_DIN: begin
          if (byteDone) begin
            gotData_q <= 1'b1;
          end
        end
        PH_END:  phase_q <= PH_SKIP;
        default: ;
      endcase
    end
  end

  // Read data source feeding the FIFO
  always_comb begin
    push = (src_q != SRC_NONE) && fifoInReady;
    case (idIdx_q)
      2'h0:    pushData = ID_MANUFACTURER;
      2'h1:    pushData = ID_MEMORY_TYPE;
      2'h2:    pushData = ID_CAPACITY;
      default: pushData = ID_DEVICE_LOW;
    endcase
    if (src_q == SRC_MEM) begin
      pushData = secMem[rdAddr_q];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !selected) begin
      src_q    <= SRC_NONE;
      idIdx_q  <= '0;
      rdAddr_q <= '0;
    end else if (cmdDone && (inByte == OP_READ_ID_A || inByte == OP_READ_ID_B) && !wip_q) begin
      src_q   <= SRC_ID;
      idIdx_q <= '0;
    end else if (addrDone && opcode_q == OP_SEC_READ) begin
      src_q    <= SRC_MEM;
      rdAddr_q <= {addr_q[3:0], inByte};
    end else if (push) begin
      if (src_q == SRC_ID) begin
        idIdx_q <= idIdx_q + 2'h1;
        if (idIdx_q == ID_LAST_INDEX) begin
          src_q <= SRC_NONE;
        end
      end else begin
        rdAddr_q <= rdAddr_q + 12'h001;
      end
    end
  end

  fisc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (sys_clk),
    .rst      (rst),
    .flush    (!selected),
    .inValid  (push),
    .inReady  (fifoInReady),
    .inData   (pushData),
    .outValid (fifoOutValid),
    .outReady (pop),
    .outData  (fifoData)
  );

  // Serial output on falling clock
  always_comb begin
    load    = sclkFall && (phase_q == PH_DOUT) && (outLeft_q == '0);
    pop     = load && fifoOutValid;
    outByte = load ? (fifoOutValid ? fifoData : ERASED_BYTE) : (outSr_q << step);
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !selected) begin
      outSr_q   <= '0;
      outLeft_q <= '0;
      ioOut_q   <= '0;
      ioOeN_q   <= OE_N_IDLE;
    end else begin
      ioOeN_q <= (phase_q != PH_DOUT) ? OE_N_IDLE : (quadCmdMode ? OE_N_QUAD : OE_N_SPI);
      if (sclkFall && phase_q == PH_DOUT) begin
        outSr_q   <= outByte;
        outLeft_q <= load ? BYTE_BITS - step : outLeft_q - step;
        ioOut_q   <= '0;
        if (quadCmdMode) begin
          ioOut_q <= outByte[7:4];
        end else begin
          ioOut_q[SO_LANE] <= outByte[7];
        end
      end
    end
  end

  // Security program page buffer
  always_ff @(posedge sys_clk) begin
    if (selected && byteDone && phase_q == PH_DIN) begin
      pageBuf[pageIdx_q] <= inByte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || (cmdDone && inByte == OP_SEC_PROG && sec_q == SEC_IDLE)) begin
      pageMask_q <= '0;
      pageIdx_q  <= '0;
      pageSel_q  <= '0;
    end else if (addrDone) begin
      pageSel_q <= addr_q[3:0];
      pageIdx_q <= inByte;
    end else if (byteDone && phase_q == PH_DIN) begin
      pageMask_q[pageIdx_q] <= 1'b1;
      pageIdx_q             <= pageIdx_q + 8'h01;
    end
  end

  // Security region cycles
  always_comb begin
    execOk   = wel_q && !secLockBit && !wip_q && !suspP_q && addrOk_q;
    eraseGo  = csRise && phase_q == PH_END && opcode_q == OP_SEC_ERASE
               && execOk && !suspE_q;
    progGo   = csRise && phase_q == PH_DIN && gotData_q && opcode_q == OP_SEC_PROG
               && execOk;
    walkLast = (sec_q == SEC_ERASE && walk_q == SEC_LAST_ADDR)
               || (sec_q == SEC_PROG && walk_q[7:0] == PAGE_LAST);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sec_q    <= SEC_IDLE;
      walk_q   <= '0;
      secCnt_q <= '0;
    end else begin
      if (secCnt_q != '0) begin
        secCnt_q <= secCnt_q - 24'h000001;
      end
      case (sec_q)
        SEC_IDLE: begin
          walk_q <= '0;
          if (eraseGo) begin
            sec_q    <= SEC_ERASE;
            secCnt_q <= 24'(ERASE_CYCLES);
          end else if (progGo) begin
            sec_q    <= SEC_PROG;
            secCnt_q <= 24'(PROG_CYCLES);
          end
        end
        SEC_ERASE, SEC_PROG: begin
          walk_q <= walk_q + 12'h001;
          if (walkLast) begin
            sec_q <= SEC_WAIT;
          end
        end
        SEC_WAIT: begin
          if (secCnt_q == '0) begin
            sec_q <= SEC_IDLE;
          end
        end
        default: sec_q <= SEC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sec_q == SEC_ERASE) begin
      secMem[walk_q] <= ERASED_BYTE;
    end else if (sec_q == SEC_PROG && pageMask_q[walk_q[7:0]]) begin
      secMem[{pageSel_q, walk_q[7:0]}] <= secMem[{pageSel_q, walk_q[7:0]}]
                                          & pageBuf[walk_q[7:0]];
    end
  end

  // Write-enable latch
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wel_q <= 1'b0;
    end else if (cmdDone && inByte == OP_WRITE_ENABLE && !wip_q) begin
      wel_q <= 1'b1;
    end else if ((cmdDone && inByte == OP_WRITE_DISABLE) || walkLast || mainWelClear) begin
      wel_q <= 1'b0;
    end
  end

  // Suspend, resume and busy flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      suspP_q  <= 1'b0;
      suspE_q  <= 1'b0;
      pause_q  <= 1'b0;
      latCnt_q <= '0;
    end else if (cmdDone && inByte == OP_SUSPEND && wip_q && !suspP_q && !suspE_q
                 && mainOpActive && sec_q == SEC_IDLE) begin
      suspP_q  <= !mainOpErase;
      suspE_q  <= mainOpErase;
      pause_q  <= 1'b1;
      latCnt_q <= 5'(SUSPEND_CYCLES - 1);
    end else if (cmdDone && inByte == OP_RESUME && (suspP_q || suspE_q) && !wip_q) begin
      suspP_q  <= 1'b0;
      suspE_q  <= 1'b0;
      pause_q  <= 1'b0;
      latCnt_q <= '0;
    end else if (latCnt_q != '0) begin
      latCnt_q <= latCnt_q - 5'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wip_q <= 1'b0;
    end else begin
      wip_q <= (sec_q != SEC_IDLE) || eraseGo || progGo
               || (mainOpActive && (!pause_q || latCnt_q != '0));
    end
  end

  // Hand-off of opcodes served elsewhere
  always_comb begin
    handled = inByte inside {OP_READ_ID_A, OP_READ_ID_B, OP_SUSPEND, OP_RESUME, OP_SEC_ERASE,
                             OP_SEC_PROG, OP_SEC_READ, OP_WRITE_ENABLE, OP_WRITE_DISABLE};
    refused = (suspP_q && (inByte == OP_WRITE_REG_A || inByte == OP_WRITE_REG_B
                           || isErase(inByte) || isProgram(inByte)))
              || (suspE_q && (inByte == OP_WRITE_REG_A || inByte == OP_WRITE_REG_B
                              || isErase(inByte)));
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmdCode_q    <= '0;
      cmdStrobe_q  <= 1'b0;
      cmdRefused_q <= 1'b0;
    end else begin
      cmdStrobe_q  <= cmdDone && !handled && !refused;
      cmdRefused_q <= cmdDone && !handled && refused;
      if (cmdDone) begin
        cmdCode_q <= inByte;
      end
    end
  end

  assign ioOut            = ioOut_q;
  assign ioOeN            = ioOeN_q;
  assign mainPause        = pause_q;
  assign cmdCode          = cmdCode_q;
  assign cmdStrobe        = cmdStrobe_q;
  assign cmdRefused       = cmdRefused_q;
  assign writeInProgress  = wip_q;
  assign writeEnableLatch = wel_q;
  assign suspendProgram   = suspP_q;
  assign suspendErase     = suspE_q;
endmodule

// ==== fisc_core_props.sv ====
module fisc_core_chk
  import fisc_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // Pins and modes
  input wire logic       csN,
  input wire logic       quadCmdMode,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOeN,
  // Main engine and flags
  input wire logic       mainOpActive,
  input wire logic       mainOpErase,
  input wire logic       mainPause,
  input wire logic       cmdRefused,
  input wire logic       writeInProgress,
  input wire logic       writeEnableLatch,
  input wire logic       suspendProgram,
  input wire logic       suspendErase
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  chk_oe_idle: assert property (csN [*6] |-> ioOeN == OE_N_IDLE && ioOut == 4'h0)
    else $error("link driven while deselected");
  chk_oe_single: assert property (!quadCmdMode && ioOeN != OE_N_IDLE |-> ioOeN == OE_N_SPI)
    else $error("wrong lanes enabled");
  chk_sus_gate: assert property ($rose(suspendProgram) || $rose(suspendErase)
    |-> $past(writeInProgress) && $past(mainOpActive)) else $error("suspend while idle");
  chk_sus_kind: assert property ($rose(suspendErase) || $rose(suspendProgram)
    |-> suspendErase == $past(mainOpErase)) else $error("suspend flag of wrong kind");
  chk_busy_drop: assert property ($rose(suspendProgram) || $rose(suspendErase)
    |-> ##[1:22] !writeInProgress) else $error("busy stuck after suspend");
  chk_pause_flags: assert property (mainPause == (suspendProgram || suspendErase))
    else $error("pause does not follow suspend");
  chk_resume_gate: assert property ($fell(suspendProgram) || $fell(suspendErase)
    |-> !$past(writeInProgress)) else $error("resume while busy");
  chk_resume_busy: assert property ($fell(mainPause) |-> ##[1:4] writeInProgress)
    else $error("busy late after resume");
  chk_refuse_sus: assert property (cmdRefused |-> suspendProgram || suspendErase)
    else $error("refusal without suspend");
  chk_wel_drop: assert property ($fell(writeInProgress) && !mainPause |-> !writeEnableLatch)
    else $error("latch held at cycle end");

  cover property ($rose(suspendProgram));
  cover property ($rose(suspendErase));
  cover property (cmdRefused);
  cover property ($fell(writeInProgress) && !mainPause);
endmodule

// ==== fisc_host.sv ====
module fisc_host
  import fisc_pkg::*;
(
  // Clock
  input wire logic       sys_clk,
  // Link pins
  output logic           csN,
  output logic           sclk,
  output logic     [3:0] ioIn,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOeN
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    ioIn = 4'h0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Bytes in, then nRx bytes out; power-down codes are never sent
  task automatic frame(input logic [7:0] tx[$], input int nRx, output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    tick(1);
    csN <= 1'b0;
    tick(4);
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        sclk <= 1'b0;
        ioIn[0] <= tx[i][k];
        tick(4);
        sclk <= 1'b1;
        tick(4);
      end
    end
    repeat (nRx) begin
      for (int k = 7; k >= 0; k--) begin
        sclk <= 1'b0;
        ioIn <= ~ioIn;
        tick(4);
        sclk <= 1'b1;
        tick(3);
        @(negedge sys_clk) b[k] = ioOut[SO_LANE] ^ ioOeN[SO_LANE];
        tick(1);
      end
      rx.push_back(b);
    end
    // Select rises with no clock rise after the last bit
    sclk <= 1'b0;
    tick(4);
    csN <= 1'b1;
    ioIn <= ~ioIn;
    tick(8);
  endtask
endmodule

// ==== tb.sv ====
`define CHK(g, e) begin \
  samplesChecked++; \
  if ((g) !== (e)) begin \
    errTotal++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); \
  end \
end

module tb
  import fisc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Clock, reset, pins
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       csN, sclk;
  logic [3:0] ioIn, ioOut, ioOeN;
  // Modes and main engine
  logic       quadCmdMode = 1'b0;
  logic       highSpeedClk = 1'b0;
  logic       addr4Byte = 1'b0;
  logic       secLockBit = 1'b0;
  logic       mainOpActive = 1'b0;
  logic       mainOpErase = 1'b0;
  logic       mainWelClear = 1'b0;
  // Design outputs
  logic [7:0] cmdCode;
  logic       mainPause, cmdStrobe, cmdRefused;
  logic       writeInProgress, writeEnableLatch, suspendProgram, suspendErase;
  // Bookkeeping
  int         errTotal = 0;
  int         samplesChecked = 0;
  int         refCnt = 0;
  int         stbCnt = 0;
  logic [7:0] rx[$];
  logic [7:0] progRef[5] = '{OP_WRITE_REG_B, OP_ERASE_64K_B, OP_PROG_QUAD_A,
                             OP_ERASE_CHIP_A, OP_PROG_A};
  logic [7:0] eraseRef[3] = '{OP_WRITE_REG_A, OP_ERASE_32K_A, OP_ERASE_4K_B};

  fisc_core #(.SEC_ERASE_TIME_US(210), .PROG_TIME_US(15)) dut (
    .sys_clk(sys_clk), .rst(rst), .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut),
    .ioOeN(ioOeN), .quadCmdMode(quadCmdMode), .highSpeedClk(highSpeedClk),
    .addr4Byte(addr4Byte), .secLockBit(secLockBit), .mainOpActive(mainOpActive),
    .mainOpErase(mainOpErase), .mainWelClear(mainWelClear), .mainPause(mainPause),
    .cmdCode(cmdCode), .cmdStrobe(cmdStrobe), .cmdRefused(cmdRefused),
    .writeInProgress(writeInProgress), .writeEnableLatch(writeEnableLatch),
    .suspendProgram(suspendProgram), .suspendErase(suspendErase));
  fisc_host host (.sys_clk(sys_clk), .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut(ioOut),
    .ioOeN(ioOeN));

  initial forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (cmdRefused === 1'b1) refCnt <= refCnt + 1;
    if (cmdStrobe === 1'b1) stbCnt <= stbCnt + 1;
  end

  task automatic endOfTest;
    $display("Comparisons %0d, mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] tx[$]);
    logic [7:0] r[$];
    host.frame(tx, 0, r);
  endtask

  task automatic expectRefuse(input logic [7:0] op, input int exp);
    int r0;
    r0 = refCnt;
    cmd({op});
    `CHK(refCnt - r0, exp)
    `CHK(cmdCode, op)
  endtask

  task automatic waitIdle;
    while (writeInProgress === 1'b1) @(posedge sys_clk);
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
    host.frame({OP_READ_ID_A}, 5, rx);
    `CHK({rx[0], rx[1]}, {ID_MANUFACTURER, ID_MEMORY_TYPE})
    `CHK({rx[2], rx[3], rx[4]}, {ID_CAPACITY, ID_DEVICE_LOW, 8'hFF})
    host.frame({OP_READ_ID_B}, 1, rx);
    `CHK(rx[0], ID_MANUFACTURER)
    cmd({OP_SEC_ERASE, 8'h00, 8'h00, 8'h00});
    `CHK(writeInProgress, 1'b0)
    cmd({OP_WRITE_ENABLE});
    `CHK(writeEnableLatch, 1'b1)
    cmd({OP_SEC_ERASE, 8'h00, 8'h00, 8'h00, 8'h00});
    `CHK(writeInProgress, 1'b0)
    secLockBit <= 1'b1;
    cmd({OP_SEC_ERASE, 8'h00, 8'h00, 8'h00});
    `CHK(writeInProgress, 1'b0)
    secLockBit <= 1'b0;
    cmd({OP_SEC_ERASE, 8'h00, 8'h00, 8'h00});
    `CHK(writeInProgress, 1'b1)
    waitIdle();
    `CHK(writeEnableLatch, 1'b0)
    cmd({OP_WRITE_ENABLE});
    cmd({OP_SEC_PROG, 8'h01, 8'h0F, 8'h00, 8'h55});
    `CHK(writeInProgress, 1'b0)
    cmd({OP_WRITE_ENABLE});
    cmd({OP_SEC_PROG, 8'h00, 8'h0F, 8'hFE, 8'hAB, 8'hCD});
    `CHK(writeInProgress, 1'b1)
    waitIdle();
    addr4Byte <= 1'b1;
    host.frame({OP_SEC_READ, 8'h00, 8'h00, 8'h0F, 8'hFE, 8'h00}, 4, rx);
    addr4Byte <= 1'b0;
    `CHK({rx[0], rx[1], rx[2], rx[3]}, {8'hAB, 8'hCD, ERASED_BYTE, ERASED_BYTE})
    mainOpActive <= 1'b1;
    cmd({OP_SUSPEND});
    `CHK({suspendProgram, mainPause}, 2'h3)
    repeat (10) @(posedge sys_clk);
    `CHK(writeInProgress, 1'b0)
    foreach (progRef[i]) expectRefuse(progRef[i], 1);
    cmd({OP_WRITE_ENABLE});
    cmd({OP_SEC_ERASE, 8'h00, 8'h00, 8'h00});
    cmd({OP_SEC_PROG, 8'h00, 8'h00, 8'h00, 8'h5A});
    `CHK({writeEnableLatch, writeInProgress}, 2'h2)
    cmd({OP_RESUME});
    `CHK({suspendProgram, writeInProgress}, 2'h1)
    mainWelClear <= 1'b1;
    @(posedge sys_clk);
    mainWelClear <= 1'b0;
    mainOpActive <= 1'b0;
    mainOpErase <= 1'b1;
    repeat (4) @(posedge sys_clk);
    `CHK(writeEnableLatch, 1'b0)
    mainOpActive <= 1'b1;
    cmd({OP_SUSPEND});
    `CHK(suspendErase, 1'b1)
    foreach (eraseRef[i]) expectRefuse(eraseRef[i], 1);
    expectRefuse(OP_SEC_PROG, 0);
    expectRefuse(OP_PROG_B, 0);
    cmd({OP_WRITE_ENABLE});
    cmd({OP_SEC_ERASE, 8'h00, 8'h00, 8'h00});
    `CHK(writeInProgress, 1'b0)
    cmd({OP_SEC_PROG, 8'h00, 8'h00, 8'h00, 8'h5A});
    `CHK(writeInProgress, 1'b1)
    waitIdle();
    `CHK(stbCnt > 0, 1'b1)
    cmd({OP_RESUME});
    `CHK(suspendErase, 1'b0)
    host.frame({OP_READ_ID_A}, 1, rx);
    `CHK(rx[0], 8'hFF)
    mainOpActive <= 1'b0;
    cmd({OP_SUSPEND});
    `CHK({suspendProgram, suspendErase}, 2'h0)
    cmd({OP_RESUME});
    `CHK(writeInProgress, 1'b0)
    mainOpActive <= 1'b1;
    cmd({OP_SUSPEND});
    `CHK(suspendErase, 1'b1)
    rst <= 1'b1;
    mainOpActive <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    `CHK({suspendErase, mainPause, writeInProgress}, 3'h0)
    endOfTest();
  end

  initial begin
    #(60000 * CLK_PERIOD_NS);
    errTotal++;
    endOfTest();
  end
endmodule

bind fisc_core fisc_core_chk chk (
  .sys_clk(sys_clk), .rst(rst), .csN(csN), .quadCmdMode(quadCmdMode), .ioOut(ioOut),
  .ioOeN(ioOeN), .mainOpActive(mainOpActive), .mainOpErase(mainOpErase),
  .mainPause(mainPause), .cmdRefused(cmdRefused), .writeInProgress(writeInProgress),
  .writeEnableLatch(writeEnableLatch), .suspendProgram(suspendProgram),
  .suspendErase(suspendErase));
